// >>> src/rcs_pkg.sv
// Constants, types and register map of the reset and clock sequencer.
package rcs_pkg;

  // Register byte offsets on the APB slave.
  localparam logic [11:0] OFS_CAUSE  = 12'h000;
  localparam logic [11:0] OFS_CONFIG = 12'h004;
  localparam logic [11:0] OFS_STATUS = 12'h008;

  // Configuration register fields.
  localparam int CFG_SHORT_WAKE = 0;
  localparam int CFG_HALT_OK    = 1;
  localparam logic [1:0] CFG_RESET = 2'h0;

  // Status register fields.
  localparam int STS_INTERNAL_RESET   = 0;
  localparam int STS_CLK_ON = 1;
  localparam int STS_PIN_OE = 2;
  localparam int STS_WDT_OFF = 3;

  // Reset cause layout, bit 7 down to bit 0.
  typedef struct packed {
    logic por;
    logic pin;
    logic wdt;
    logic bad_op;
    logic bad_addr;
    logic rsvd;
    logic low_v;
    logic mon;
  } rcs_cause_s;

  localparam rcs_cause_s CAUSE_POR = 8'h80;
  localparam rcs_cause_s CAUSE_CLR = 8'h00;

  // Reset vectors, address of the high byte.
  localparam logic [15:0] VEC_USER = 16'hFFFE;
  localparam logic [15:0] VEC_MON  = 16'hFEFE;

  // Watchdog service address on the CPU bus.
  localparam logic [15:0] WDT_SVC_ADDR = 16'hFFFF;

  // Sequencing counts in internal oscillator cycles.
  localparam int POR_CYC    = 4096;
  localparam int DRIVE_CYC  = 32;
  localparam int HOLD_CYC   = 32;
  localparam int PIN_MIN    = 67;
  localparam int PIN_POR    = 4163;
  localparam int SREC_LONG  = 4096;
  localparam int SREC_SHORT = 32;
  localparam int TICK_CYC   = 8176;

  // Kept bits of the stabilisation counter on a service write.
  localparam logic [12:0] SVC_KEEP = 13'h001F;

  typedef enum logic [2:0] {
    ST_RUN,
    ST_POR,
    ST_DRIVE,
    ST_HOLD,
    ST_EXT,
    ST_STOP,
    ST_SREC
  } rcs_state_e;

endpackage

// >>> src/rcs_top.sv
// Reset sequencing, clock gating and watchdog prescaler block.
// Behaviour
// - Bus clock runs at a quarter of the selected oscillator or PLL source.
// - After power-on or low voltage, pin stays low 4096 plus 32 cycles, clocks off 32 more.
// - Stop exit runs only the counter, then clocks after 4096 or 32 cycles.
// - Wait mode stops CPU clock but keeps peripheral clock running.
// - Every source asserts internal reset and picks user or monitor vector.
// - Internal resets clear the stabilisation counter, the pin alone does not.
// - Each reset source sets its own flag in the reset cause register; a pin pulse shorter than 67 cycles sets none.
// - Pin flag sets when pin is low 67 cycles, or 4163 after power-on or low voltage until run.
// - Internal sources drive the pin low 32 cycles, then hold 32 more.
// - Power-on and low voltage drive the pin low for 4096 plus 32 cycles.
// - Watchdog request is taken independently of the bus clock phase.
// - Power-on asserts reset, enables clock generator output, releases late.
// - Power-on sets its flag and clears every other cause flag.
// - Watchdog overflow resets the device and sets the watchdog flag.
// - A write to FFFF clears watchdog and counter bits 12 to 5.
// - Counter gives a watchdog tick every 8176 cycles unless an internal or supply reset, stop or service write clears it.
// - Watchdog is disabled only by test voltage in monitor or break state.
// - Illegal opcodes, or stop without halt permit, set flag and reset.
// - Only opcode fetches from unmapped addresses set flag and reset.
// - Low voltage sets its flag, drives pin 4096 plus 32, releases later.
// - Monitor entry reset request performs an internal reset.
// - Counter free-runs after resets, stop clears it, short wake selects 32.
// - Bus clock is the clock generator output divided by two.
//
// The register offsets and the APB interface to the registers were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none

module rcs_top #(
  parameter int POR_PIN_CYC = rcs_pkg::POR_CYC + rcs_pkg::DRIVE_CYC,
  parameter int PIN_POR_CYC = rcs_pkg::PIN_POR,
  parameter int TICK_CYC    = rcs_pkg::TICK_CYC,
  parameter int SREC_LONG   = rcs_pkg::SREC_LONG,
  parameter int WDT_W       = 6
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic [11:0] paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        osc_select_clock,
  input  wire logic        divided_pll_clock,
  input  wire logic        use_pll,
  input  wire logic        power_on_pulse,
  input  wire logic        low_voltage_det,
  input  wire logic        rst_pin_in,
  output logic             rst_pin_out,
  output logic             rst_pin_oe,
  input  wire logic        test_high_voltage_rst,
  input  wire logic        test_high_voltage_irq,
  input  wire logic        monitor_mode,
  input  wire logic        break_state,
  input  wire logic        monitor_entry_reset,
  input  wire logic        illegal_opcode,
  input  wire logic        stop_op,
  input  wire logic        fetch_opcode,
  input  wire logic        fetch_unmapped,
  input  wire logic        cpu_wr,
  input  wire logic [15:0] cpu_addr,
  input  wire logic        wake_evt,
  input  wire logic        wait_mode,
  output logic             internal_reset,
  output logic             clockgen_output,
  output logic             periph_clk_en,
  output logic             cpu_clk_en,
  output logic [15:0]      vector_addr
);

  if (WDT_W < 2 || WDT_W > 16) begin : g_chk_w
    $error("WDT_W must lie between 2 and 16.");
  end
  if (PIN_POR_CYC <= POR_PIN_CYC || PIN_POR_CYC > 8191) begin : g_chk_p
    $error("PIN_POR_CYC must exceed POR_PIN_CYC and fit 13 bits.");
  end
  if (TICK_CYC < 64 || TICK_CYC > 8191) begin : g_chk_t
    $error("TICK_CYC must lie between 64 and 8191.");
  end
  if (SREC_LONG < 33 || SREC_LONG > 8191) begin : g_chk_s
    $error("SREC_LONG must lie between 33 and 8191.");
  end

  function automatic logic [12:0] last13(input int n);
    last13 = 13'(n - 1);
  endfunction

  // Asynchronous pins: power-on, low voltage, reset pin, test voltages.
  logic [4:0] sync1_ff;
  logic [4:0] sync2_ff;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_ff <= 5'h1C;
      sync2_ff <= 5'h1C;
    end else begin
      sync1_ff <= {~rst_pin_in, power_on_pulse, low_voltage_det,
                   test_high_voltage_rst, test_high_voltage_irq};
      sync2_ff <= sync1_ff;
    end
  end

  logic pin_low_s;
  logic por_s;
  logic lvi_s;
  logic thv_rst_s;
  logic thv_irq_s;
  assign pin_low_s = sync2_ff[4];
  assign por_s     = sync2_ff[3];
  assign lvi_s     = sync2_ff[2];
  assign thv_rst_s = sync2_ff[1];
  assign thv_irq_s = sync2_ff[0];

  rcs_pkg::rcs_state_e st_ff;
  logic [12:0] seq_cnt_ff;
  logic [12:0] sim_cnt_ff;
  logic [WDT_W-1:0] wdt_cnt_ff;
  logic [1:0] cfg_ff;
  logic [2:0] oe_hist_ff;
  logic oe_ff;
  logic internal_reset_ff;
  logic por_seq_ff;
  logic [12:0] pin_cnt_ff;
  rcs_pkg::rcs_cause_s cause_ff;

  logic run;
  logic ext_low;
  logic wdt_off;
  logic tick;
  logic wdt_ev;
  logic bad_op_ev;
  logic bad_addr_ev;
  logic mon_ev;
  logic int_ev;
  logic pwr_ev;
  logic stop_go;
  logic service;
  logic [12:0] srec_last;
  logic [12:0] pin_last;

  assign run = (st_ff == rcs_pkg::ST_RUN) && !internal_reset_ff;

  // The pin reads low for a few cycles after we release it; that echo of
  // our own drive must not be mistaken for an external reset.
  assign ext_low = pin_low_s && !oe_ff && (oe_hist_ff == 3'h0);

  assign wdt_off = (monitor_mode && (thv_rst_s || thv_irq_s)) ||
                   (break_state && thv_rst_s);

  assign tick = (sim_cnt_ff == last13(TICK_CYC));
  assign wdt_ev = tick && (&wdt_cnt_ff) && !wdt_off && !internal_reset_ff;
  assign bad_op_ev = run &&
    (illegal_opcode || (stop_op && !cfg_ff[rcs_pkg::CFG_HALT_OK]));
  assign bad_addr_ev = run && fetch_opcode && fetch_unmapped;
  assign mon_ev = monitor_entry_reset && !internal_reset_ff;
  assign int_ev = wdt_ev || bad_op_ev || bad_addr_ev || mon_ev;
  assign pwr_ev = por_s || lvi_s;
  assign stop_go = run && stop_op && cfg_ff[rcs_pkg::CFG_HALT_OK];
  assign service = run && cpu_wr && (cpu_addr == rcs_pkg::WDT_SVC_ADDR);
  assign srec_last = cfg_ff[rcs_pkg::CFG_SHORT_WAKE] ?
                     last13(rcs_pkg::SREC_SHORT) : last13(SREC_LONG);
  assign pin_last = por_seq_ff ? last13(PIN_POR_CYC)
                               : last13(rcs_pkg::PIN_MIN);

  // Reset and stop sequencer.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_ff      <= rcs_pkg::ST_POR;
      seq_cnt_ff <= 13'h0000;
    end else if (pwr_ev) begin
      st_ff      <= rcs_pkg::ST_POR;
      seq_cnt_ff <= 13'h0000;
    end else if (int_ev && st_ff != rcs_pkg::ST_POR) begin
      st_ff      <= rcs_pkg::ST_DRIVE;
      seq_cnt_ff <= 13'h0000;
    end else begin
      unique case (st_ff)
        rcs_pkg::ST_RUN: begin
          if (ext_low) begin
            st_ff <= rcs_pkg::ST_EXT;
          end else if (stop_go) begin
            st_ff <= rcs_pkg::ST_STOP;
          end
        end
        rcs_pkg::ST_POR: begin
          if (seq_cnt_ff == last13(POR_PIN_CYC)) begin
            st_ff      <= rcs_pkg::ST_HOLD;
            seq_cnt_ff <= 13'h0000;
          end else begin
            seq_cnt_ff <= seq_cnt_ff + 13'h0001;
          end
        end
        rcs_pkg::ST_DRIVE: begin
          if (seq_cnt_ff == last13(rcs_pkg::DRIVE_CYC)) begin
            st_ff      <= rcs_pkg::ST_HOLD;
            seq_cnt_ff <= 13'h0000;
          end else begin
            seq_cnt_ff <= seq_cnt_ff + 13'h0001;
          end
        end
        rcs_pkg::ST_HOLD: begin
          if (ext_low) begin
            st_ff <= rcs_pkg::ST_EXT;
          end else if (seq_cnt_ff == last13(rcs_pkg::HOLD_CYC)) begin
            st_ff      <= rcs_pkg::ST_RUN;
            seq_cnt_ff <= 13'h0000;
          end else begin
            seq_cnt_ff <= seq_cnt_ff + 13'h0001;
          end
        end
        rcs_pkg::ST_EXT: begin
          if (!pin_low_s) begin
            st_ff      <= rcs_pkg::ST_HOLD;
            seq_cnt_ff <= 13'h0000;
          end
        end
        rcs_pkg::ST_STOP: begin
          if (ext_low) begin
            st_ff <= rcs_pkg::ST_EXT;
          end else if (wake_evt) begin
            st_ff      <= rcs_pkg::ST_SREC;
            seq_cnt_ff <= 13'h0000;
          end
        end
        rcs_pkg::ST_SREC: begin
          if (ext_low) begin
            st_ff <= rcs_pkg::ST_EXT;
          end else if (seq_cnt_ff == srec_last) begin
            st_ff      <= rcs_pkg::ST_RUN;
            seq_cnt_ff <= 13'h0000;
          end else begin
            seq_cnt_ff <= seq_cnt_ff + 13'h0001;
          end
        end
        default: begin
          st_ff      <= rcs_pkg::ST_POR;
          seq_cnt_ff <= 13'h0000;
        end
      endcase
    end
  end

  // Internal reset and pin drive follow the state one cycle later.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      internal_reset_ff    <= 1'b1;
      oe_ff      <= 1'b1;
      oe_hist_ff <= 3'h7;
    end else begin
      internal_reset_ff <= (st_ff == rcs_pkg::ST_POR) || (st_ff == rcs_pkg::ST_DRIVE) ||
                 (st_ff == rcs_pkg::ST_HOLD) || (st_ff == rcs_pkg::ST_EXT);
      oe_ff   <= (st_ff == rcs_pkg::ST_POR) ||
                 (st_ff == rcs_pkg::ST_DRIVE);
      oe_hist_ff <= {oe_hist_ff[1:0], oe_ff};
    end
  end

  // Stabilisation counter; it runs on the rising edge since this block
  // has one clock, which shifts its phase by half a cycle only.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sim_cnt_ff <= 13'h0000;
    end else if (pwr_ev || int_ev || stop_go) begin
      sim_cnt_ff <= 13'h0000;
    end else if (service) begin
      sim_cnt_ff <= sim_cnt_ff & rcs_pkg::SVC_KEEP;
    end else if (tick) begin
      sim_cnt_ff <= 13'h0000;
    end else begin
      sim_cnt_ff <= sim_cnt_ff + 13'h0001;
    end
  end

  // Watchdog counter advances on prescaler ticks, not on bus clock phases.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wdt_cnt_ff <= '0;
    end else if (internal_reset_ff || service || wdt_off) begin
      wdt_cnt_ff <= '0;
    end else if (tick) begin
      wdt_cnt_ff <= wdt_cnt_ff + WDT_W'(1);
    end
  end

  // Reset pin low-time measure, saturating.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_cnt_ff <= 13'h0000;
      por_seq_ff <= 1'b1;
    end else begin
      if (!pin_low_s) begin
        pin_cnt_ff <= 13'h0000;
      end else if (pin_cnt_ff != 13'h1FFF) begin
        pin_cnt_ff <= pin_cnt_ff + 13'h0001;
      end
      if (pwr_ev) begin
        por_seq_ff <= 1'b1;
      end else if (st_ff == rcs_pkg::ST_RUN) begin
        por_seq_ff <= 1'b0;
      end
    end
  end

  // Reset cause flags; only reset events touch them.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cause_ff <= rcs_pkg::CAUSE_POR;
    end else if (por_s) begin
      cause_ff <= rcs_pkg::CAUSE_POR;
    end else begin
      if (lvi_s) begin
        cause_ff.low_v <= 1'b1;
      end
      if (pin_low_s && pin_cnt_ff == pin_last) begin
        cause_ff.pin <= 1'b1;
      end
      if (wdt_ev) begin
        cause_ff.wdt <= 1'b1;
      end
      if (bad_op_ev) begin
        cause_ff.bad_op <= 1'b1;
      end
      if (bad_addr_ev) begin
        cause_ff.bad_addr <= 1'b1;
      end
      if (mon_ev) begin
        cause_ff.mon <= 1'b1;
      end
    end
  end

  // Clock dividers: source over two is the clock generator output, and
  // that over two again is the bus clock.
  logic src_tick;
  logic cg_tick;
  logic bus_tick;
  logic cg_ph_ff;
  logic bus_ph_ff;
  logic clk_on;
  assign src_tick = use_pll ? divided_pll_clock : osc_select_clock;
  assign cg_tick  = src_tick && cg_ph_ff;
  assign bus_tick = cg_tick && bus_ph_ff;
  assign clk_on   = (st_ff == rcs_pkg::ST_RUN);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cg_ph_ff  <= 1'b0;
      bus_ph_ff <= 1'b0;
    end else begin
      if (src_tick) begin
        cg_ph_ff <= !cg_ph_ff;
      end
      if (cg_tick) begin
        bus_ph_ff <= !bus_ph_ff;
      end
    end
  end

  logic cg_out_ff;
  logic periph_en_ff;
  logic cpu_en_ff;
  logic [15:0] vec_ff;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cg_out_ff    <= 1'b0;
      periph_en_ff <= 1'b0;
      cpu_en_ff    <= 1'b0;
    end else begin
      cg_out_ff    <= cg_tick;
      periph_en_ff <= bus_tick && clk_on;
      cpu_en_ff    <= bus_tick && clk_on && !wait_mode;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      vec_ff <= rcs_pkg::VEC_USER;
    end else begin
      vec_ff <= monitor_mode ? rcs_pkg::VEC_MON : rcs_pkg::VEC_USER;
    end
  end

  // APB slave with zero wait states; pready is registered from the setup cycle, high in the access cycle.
  logic [31:0] prdata_ff;
  logic pready_ff;
  logic pslverr_ff;
  logic [31:0] rd_val;
  logic rd_ok;
  logic wr_go;

  always_comb begin
    rd_val = 32'h0000_0000;
    rd_ok  = 1'b1;
    unique case (paddr)
      rcs_pkg::OFS_CAUSE:  rd_val = {24'h000000, cause_ff};
      rcs_pkg::OFS_CONFIG: rd_val = {30'h0000_0000, cfg_ff};
      rcs_pkg::OFS_STATUS: rd_val = {28'h000_0000, wdt_off, oe_ff,
                                     clk_on, internal_reset_ff};
      default: rd_ok = 1'b0;
    endcase
  end

  assign wr_go = psel && penable && pready_ff && pwrite && rd_ok;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_ff  <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff  <= 32'h0000_0000;
    end else begin
      pready_ff  <= psel && !penable;
      pslverr_ff <= psel && !penable &&
                    (!rd_ok || (pwrite && paddr != rcs_pkg::OFS_CONFIG));
      prdata_ff  <= (psel && !penable && !pwrite) ? rd_val : 32'h0000_0000;
    end
  end

  // Configuration returns to defaults with every internal reset.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_ff <= rcs_pkg::CFG_RESET;
    end else if (internal_reset_ff) begin
      cfg_ff <= rcs_pkg::CFG_RESET;
    end else if (wr_go && paddr == rcs_pkg::OFS_CONFIG) begin
      cfg_ff <= pwdata[1:0];
    end
  end

  assign prdata          = prdata_ff;
  assign pready          = pready_ff;
  assign pslverr         = pslverr_ff;
  assign rst_pin_out     = 1'b0;
  assign rst_pin_oe      = oe_ff;
  assign internal_reset  = internal_reset_ff;
  assign clockgen_output = cg_out_ff;
  assign periph_clk_en   = periph_en_ff;
  assign cpu_clk_en      = cpu_en_ff;
  assign vector_addr     = vec_ff;

endmodule

`default_nettype wire

// >>> testbench/rcs_top_props.sv
// Concurrent checks on the ports of the reset and clock sequencer.
`timescale 1ns/10ps
`default_nettype none

module rcs_top_props #(
  parameter int POR_PIN_CYC = 4128
) (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic [11:0] paddr,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        power_on_pulse,
  input wire logic        low_voltage_det,
  input wire logic        rst_pin_out,
  input wire logic        rst_pin_oe,
  input wire logic        monitor_mode,
  input wire logic        wait_mode,
  input wire logic        internal_reset,
  input wire logic        periph_clk_en,
  input wire logic        cpu_clk_en,
  input wire logic [15:0] vector_addr
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  // A supply event restarts the long drive, so only the tail after it counts.
  logic [15:0] drive_cnt_ff;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      drive_cnt_ff <= 16'h0000;
    end else if (!rst_pin_oe || power_on_pulse || low_voltage_det) begin
      drive_cnt_ff <= 16'h0000;
    end else begin
      drive_cnt_ff <= drive_cnt_ff + 16'h0001;
    end
  end

  sequence cause_write;
    psel && !penable && pwrite && paddr == rcs_pkg::OFS_CAUSE;
  endsequence
  sequence hold_tail;
    internal_reset [*8] ##[23:25] !internal_reset;
  endsequence

  drive_start_a: assert property (
    $rose(rst_pin_oe) |-> internal_reset && !rst_pin_out)
    else $error("pin drive without internal reset");
  drive_len_a: assert property (
    $fell(rst_pin_oe) |-> drive_cnt_ff == 16'h0020 ||
      (drive_cnt_ff >= POR_PIN_CYC && drive_cnt_ff <= POR_PIN_CYC + 4))
    else $error("pin drive length wrong");
  reset_hold_a: assert property (
    $fell(rst_pin_oe) |-> hold_tail)
    else $error("internal reset hold wrong");
  clock_gate_a: assert property (
    internal_reset |-> !periph_clk_en && !cpu_clk_en)
    else $error("clock enable during reset");
  cpu_wait_a: assert property (
    wait_mode && $past(wait_mode) |-> !cpu_clk_en)
    else $error("cpu clock during wait");
  cpu_subset_a: assert property (
    cpu_clk_en |-> periph_clk_en)
    else $error("cpu clock without peripheral clock");
  bus_div_a: assert property (
    periph_clk_en |=> !periph_clk_en [*3])
    else $error("bus clock faster than a quarter");
  vector_sel_a: assert property (
    $past(presetn) && $stable(monitor_mode) |-> vector_addr ==
      (monitor_mode ? rcs_pkg::VEC_MON : rcs_pkg::VEC_USER))
    else $error("reset vector wrong");
  cause_ro_a: assert property (
    cause_write |=> pready && pslverr)
    else $error("cause write not refused");
endmodule

`default_nettype wire

// >>> testbench/rcs_far_model.sv
// Far-side model: clock source pulses and the pulled-up reset pin.
`timescale 1ns/10ps
`default_nettype none

module rcs_far_model (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic rst_pin_out,
  input  wire logic rst_pin_oe,
  input  wire logic ext_low,
  output logic      rst_pin_in,
  output logic      osc_select_clock,
  output logic      divided_pll_clock
);
  // Oscillator pulses every cycle, the PLL source every other cycle.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      osc_select_clock  <= 1'b0;
      divided_pll_clock <= 1'b0;
    end else begin
      osc_select_clock  <= 1'b1;
      divided_pll_clock <= ~divided_pll_clock;
    end
  end

  // The pull-up wins unless the sequencer or an outside agent pulls low.
  assign rst_pin_in = rst_pin_oe ? rst_pin_out : !ext_low;
endmodule

`default_nettype wire

// >>> testbench/test_rcs_top.sv
// Self-checking bench for the reset and clock sequencer.
`timescale 1ns/10ps
`default_nettype none

module test_rcs_top;
  localparam int PPC  = 40;
  localparam int SREC = 40;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic        osc_select_clock, divided_pll_clock, use_pll, ext_low;
  logic        power_on_pulse, low_voltage_det, rst_pin_in, rst_pin_out;
  logic        rst_pin_oe, test_high_voltage_rst, test_high_voltage_irq;
  logic        monitor_mode, break_state, monitor_entry_reset, wake_evt;
  logic        illegal_opcode, stop_op, fetch_opcode, fetch_unmapped;
  logic        cpu_wr, wait_mode, internal_reset, clockgen_output;
  logic        periph_clk_en, cpu_clk_en;
  logic [15:0] cpu_addr, vector_addr;
  int          failures = 0;
  int          checked = 0;
  int          rst_seen = 0;

  initial pclk = 1'b0;
  always #50 pclk = ~pclk;
  always @(posedge pclk) rst_seen += int'(internal_reset === 1'b1);

  rcs_far_model far (.pclk, .presetn, .rst_pin_out, .rst_pin_oe, .ext_low,
    .rst_pin_in, .osc_select_clock, .divided_pll_clock);

  rcs_top #(.POR_PIN_CYC(PPC), .PIN_POR_CYC(75), .TICK_CYC(64),
    .SREC_LONG(SREC), .WDT_W(2)) dut (.pclk, .presetn, .paddr, .psel,
    .penable, .pwrite, .pwdata, .prdata, .pready, .pslverr,
    .osc_select_clock, .divided_pll_clock, .use_pll, .power_on_pulse,
    .low_voltage_det, .rst_pin_in, .rst_pin_out, .rst_pin_oe,
    .test_high_voltage_rst, .test_high_voltage_irq, .monitor_mode,
    .break_state, .monitor_entry_reset, .illegal_opcode, .stop_op,
    .fetch_opcode, .fetch_unmapped, .cpu_wr, .cpu_addr, .wake_evt,
    .wait_mode, .internal_reset, .clockgen_output, .periph_clk_en,
    .cpu_clk_en, .vector_addr);

  task automatic end_of_test;
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      failures++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic cyc(input int k);
    repeat (k) @(posedge pclk);
  endtask

  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] d, output logic [31:0] q,
                     output logic er);
    psel    <= 1'b1;
    paddr   <= a;
    pwrite  <= wr;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    q = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    // One idle edge keeps a following call from re-driving psel at once.
    @(posedge pclk);
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] m,
                    input logic [31:0] e);
    logic [31:0] q;
    logic        er;
    apb(1'b0, a, 32'h00000000, q, er);
    check(q & m, e);
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d,
                    input logic e);
    logic [31:0] q;
    logic        er;
    apb(1'b1, a, d, q, er);
    check({31'h0, er}, {31'h0, e});
  endtask

  task automatic svc;
    cpu_wr   <= 1'b1;
    cpu_addr <= rcs_pkg::WDT_SVC_ADDR;
    cyc(1);
    cpu_wr   <= 1'b0;
  endtask

  // Counts drive cycles until the sequencer lets the core run again.
  task automatic wait_run(output int drv);
    int n;
    n = 0;
    drv = 0;
    do begin
      @(posedge pclk);
      n++;
      drv += int'(rst_pin_oe === 1'b1);
    end while ((internal_reset !== 1'b0 || n < 4) && n < 3000);
    if (n >= 3000) failures++;
  endtask

  initial begin
    int          drv;
    int          n;
    int          s0;
    int          pc;
    int          cc;
    int          gc;
    logic [31:0] m;
    {psel, penable, pwrite, use_pll, ext_low, cpu_wr, wake_evt} = 7'h00;
    {power_on_pulse, low_voltage_det, monitor_mode, wait_mode} = 4'h0;
    {illegal_opcode, stop_op, fetch_opcode, fetch_unmapped} = 4'h0;
    {monitor_entry_reset, test_high_voltage_irq} = 2'h0;
    // Break state with the reset test voltage keeps the watchdog quiet until its own test.
    {break_state, test_high_voltage_rst} = 2'h3;
    {paddr, pwdata, cpu_addr} = 60'h0;
    presetn = 1'b0;
    cyc(5);
    presetn <= 1'b1;
    wait_run(drv);
    check(32'(drv >= PPC), 32'h1);
    rd(rcs_pkg::OFS_CAUSE, 32'hFF, 32'h80);
    rd(rcs_pkg::OFS_STATUS, 32'hF, 32'hA);
    wr(rcs_pkg::OFS_CAUSE, 32'hFF, 1'b1);
    wr(12'h00C, 32'h0, 1'b1);
    rd(rcs_pkg::OFS_CAUSE, 32'hFF, 32'h80);
    $display("power-on test done");
    for (int j = 0; j < 3; j++) begin
      use_pll   <= (j == 1);
      wait_mode <= (j == 2);
      cyc(4);
      {pc, cc, gc} = 96'h0;
      repeat (80) begin
        @(posedge pclk);
        pc += int'(periph_clk_en === 1'b1);
        cc += int'(cpu_clk_en === 1'b1);
        gc += int'(clockgen_output === 1'b1);
      end
      n = (j == 1) ? 10 : 20;
      check(pc, n);
      check(gc, 2 * n);
      check(cc, (j == 2) ? 0 : n);
    end
    use_pll   <= 1'b0;
    wait_mode <= 1'b0;
    $display("clock test done");
    for (int j = 0; j < 2; j++) begin
      wr(rcs_pkg::OFS_CONFIG, 32'h2 | 32'(j), 1'b0);
      stop_op <= 1'b1;
      cyc(1);
      stop_op <= 1'b0;
      cyc(4);
      rd(rcs_pkg::OFS_STATUS, 32'h2, 32'h0);
      wake_evt <= 1'b1;
      cyc(1);
      wake_evt <= 1'b0;
      n = 0;
      while (periph_clk_en !== 1'b1 && n < 300) begin
        cyc(1);
        n++;
      end
      m = (j == 1) ? 32 : SREC;
      check(32'(n >= m - 2 && n <= m + 8), 32'h1);
    end
    $display("stop test done");
    for (int k = 0; k < 4; k++) begin
      case (k)
        0: illegal_opcode <= 1'b1;
        1: {fetch_opcode, fetch_unmapped} <= 2'h3;
        2: monitor_entry_reset <= 1'b1;
        default: stop_op <= 1'b1;
      endcase
      m = (k == 1) ? 32'h08 : (k == 2) ? 32'h01 : 32'h10;
      cyc(1);
      {illegal_opcode, fetch_opcode, fetch_unmapped} <= 3'h0;
      {monitor_entry_reset, stop_op} <= 2'h0;
      wait_run(drv);
      check(drv, 32);
      rd(rcs_pkg::OFS_CAUSE, m, m);
    end
    rd(rcs_pkg::OFS_CONFIG, 32'h3, 32'h0);
    s0 = rst_seen;
    fetch_unmapped <= 1'b1;
    cyc(1);
    fetch_unmapped <= 1'b0;
    cyc(6);
    check(rst_seen - s0, 0);
    $display("internal source test done");
    for (int j = 0; j < 2; j++) begin
      ext_low <= 1'b1;
      cyc(j ? 80 : 20);
      ext_low <= 1'b0;
      wait_run(drv);
      rd(rcs_pkg::OFS_CAUSE, 32'h40, j ? 32'h40 : 32'h0);
    end
    low_voltage_det <= 1'b1;
    cyc(3);
    low_voltage_det <= 1'b0;
    wait_run(drv);
    check(32'(drv >= PPC), 32'h1);
    rd(rcs_pkg::OFS_CAUSE, 32'h02, 32'h02);
    $display("pin and supply test done");
    svc();
    {break_state, test_high_voltage_rst} <= 2'h0;
    s0 = rst_seen;
    repeat (6) begin
      cyc(100);
      svc();
    end
    check(rst_seen - s0, 0);
    n = 0;
    while (internal_reset !== 1'b1 && n < 400) begin
      cyc(1);
      n++;
    end
    check(32'(n >= 180 && n <= 265), 32'h1);
    wait_run(drv);
    rd(rcs_pkg::OFS_CAUSE, 32'h20, 32'h20);
    {monitor_mode, test_high_voltage_irq} <= 2'h3;
    s0 = rst_seen;
    cyc(400);
    check(rst_seen - s0, 0);
    check({16'h0, vector_addr}, {16'h0, rcs_pkg::VEC_MON});
    monitor_mode <= 1'b0;
    cyc(3);
    check({16'h0, vector_addr}, {16'h0, rcs_pkg::VEC_USER});
    power_on_pulse <= 1'b1;
    cyc(3);
    power_on_pulse <= 1'b0;
    wait_run(drv);
    check(32'(drv >= PPC), 32'h1);
    rd(rcs_pkg::OFS_CAUSE, 32'hFF, 32'h80);
    $display("watchdog test done");
    end_of_test();
  end

  // The tests take some 2400 cycles; this leaves a wide margin.
  initial begin
    repeat (20000) @(posedge pclk);
    failures++;
    end_of_test();
  end
endmodule

bind rcs_top rcs_top_props #(.POR_PIN_CYC(POR_PIN_CYC)) props (.pclk,
  .presetn, .paddr, .psel, .penable, .pwrite, .pready, .pslverr,
  .power_on_pulse, .low_voltage_det, .rst_pin_out, .rst_pin_oe,
  .monitor_mode, .wait_mode, .internal_reset, .periph_clk_en, .cpu_clk_en,
  .vector_addr);

`default_nettype wire
